// [dma_mem_model.sv]
// memory and peripheral model on the engine access port
`timescale 1ns/1ps
module dma_mem_model (
    // clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // wait states of external accesses
    input wire logic [1:0] ext_waits,
    // access port
    input wire logic mem_req,
    input wire logic mem_write,
    input wire logic mem_external,
    input wire logic [23:0] mem_addr,
    input wire logic [31:0] mem_wdata,
    output logic [31:0] mem_rdata,
    output logic mem_ready
);
    logic [31:0] mem_q [32];
    logic [31:0] last_q = 32'h0;
    logic [1:0] wait_q = 2'h0;
    logic [4:0] idx;

    // on-chip and external apart
    assign idx = {mem_addr[23], mem_addr[3:0]};
    // external waits ext_waits
    assign mem_ready = mem_req
        && wait_q >= (mem_external ? ext_waits : 2'h0);
    // idle: inverse of last value
    assign mem_rdata = (mem_req && !mem_write) ? mem_q[idx] : ~last_q;

    // known contents
    initial begin
        for (int i = 0; i < 32; i++) begin
            mem_q[i] = 32'ha5a5_0000 | i;
        end
    end
    // waits, writes, last value
    always @(posedge clk_sys) begin
        wait_q <= (mem_req && !mem_ready && !srst) ? wait_q + 2'h1 : 2'h0;
        last_q <= mem_rdata;
        if (mem_req && mem_write && mem_ready) begin
            mem_q[idx] <= mem_wdata;
        end
    end
endmodule : dma_mem_model

// [dma_transfer_engine.sv]
// single channel dma transfer engine with axi4-lite registers
//
// Local design decisions: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps

// Notes on behaviour
// - 24-bit counter decrements as write phase begins
// - reset clears the transfer counter
// - count-zero enable lets zero set dma flag
// - 32-bit enable register, dma half 26:16
// - enable one passes interrupt, zero blocks
// - reset clears whole interrupt enable register
// - fixed source order, repeated from bit 16
// - reserved enable bits always read zero
// - separate cpu and dma enables; sync governs
// - same priority decode for both halves
// - read then write; both finish transfer
// - resume finishes pending transfer first
// - source steps after read, destination after write
// - on-chip one cycle; off-chip read two
// - external cycles use the cpu bus sequence
// - 24-bit source and destination addresses
// - on-chip pair two cycles per transfer
// - start field: abort, phase stop, transfer stop, run
// - equal step bits leave address unchanged
// - sync field: none, source, destination, both
// - terminate bit halts transfers at zero count
module dma_transfer_engine
    import dma_transfer_pkg::*;
#(
    parameter int ADDR_W = 24,
    parameter int CNT_W = 24,
    parameter logic [23:0] ONCHIP_LO = 24'h80_0000,
    parameter logic [23:0] ONCHIP_HI = 24'h80_ffff
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // axi4-lite write address and data
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // memory and peripheral access port
    output logic mem_req,
    output logic mem_write,
    output logic mem_external,
    output logic [ADDR_W-1:0] mem_addr,
    output logic [31:0] mem_wdata,
    input wire logic [31:0] mem_rdata,
    input wire logic mem_ready,
    // interrupt sources and results
    input wire logic [IRQ_N-2:0] irq_src,
    output logic [IRQ_N-1:0] cpu_irq_sel,
    output logic dma_irq_flag,
    output logic [1:0] dma_stat
);

    // all state of the engine
    typedef struct packed {
        state_type state;
        logic [31:0] ctrl;
        logic [ADDR_W-1:0] src;
        logic [ADDR_W-1:0] dst;
        logic [CNT_W-1:0] cnt;
        logic [31:0] ie;
        logic [31:0] data;
        logic flag;
        logic aw_v;
        logic [7:0] aw_addr;
        logic w_v;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } regs_type;

    regs_type q;
    regs_type d;

    // highest priority is the lowest index; shared by both halves
    function automatic logic [IRQ_N-1:0] prio_pick(
        input logic [IRQ_N-1:0] req
    );
        logic [IRQ_N-1:0] sel;
        logic found;
        sel = '0;
        found = 1'b0;
        for (int i = 0; i < IRQ_N; i++) begin
            if (req[i] && !found) begin
                sel[i] = 1'b1;
                found = 1'b1;
            end
        end
        return sel;
    endfunction : prio_pick

    // address stepping from the up and down control bits
    function automatic logic [ADDR_W-1:0] step_addr(
        input logic [ADDR_W-1:0] addr,
        input logic up,
        input logic down
    );
        logic [ADDR_W-1:0] res;
        res = addr;
        if (up && !down) begin
            res = addr + ADDR_W'(1);
        end else if (down && !up) begin
            res = addr - ADDR_W'(1);
        end
        return res;
    endfunction : step_addr

    // byte lane merge for register writes
    function automatic logic [31:0] merge_strb(
        input logic [31:0] old,
        input logic [31:0] wdat,
        input logic [3:0] strb
    );
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = wdat[b*8 +: 8];
            end
        end
        return res;
    endfunction : merge_strb

    // register address decode, used by read and write paths
    function automatic logic addr_hit(
        input logic [7:0] addr,
        input logic [5:0] idx
    );
        return addr[7:2] == idx;
    endfunction : addr_hit

    // an address outside the on-chip range goes to an external bus
    function automatic logic is_external(input logic [ADDR_W-1:0] addr);
        return (addr < ONCHIP_LO) || (addr > ONCHIP_HI);
    endfunction : is_external

    // control fields
    logic [1:0] start_f;
    logic [1:0] sync_f;
    logic term_f;
    logic count_zero_irq_enable_f;
    logic [1:0] stat_now;
    logic can_run;
    logic [IRQ_N-1:0] dma_sel;
    logic dma_event;
    logic [31:0] ctrl_view;

    assign start_f = q.ctrl[CTRL_START_LO +: 2];
    assign sync_f = q.ctrl[CTRL_SYNC_LO +: 2];
    assign term_f = q.ctrl[CTRL_TERM];
    assign count_zero_irq_enable_f = q.ctrl[CTRL_COUNT_ZERO_IRQ_ENABLE];
    assign can_run = !(term_f && (q.cnt == '0));

    // status reflects where the sequencer is held
    always_comb begin
        case (q.state)
            ST_IDLE: stat_now = STAT_BETWEEN;
            ST_MID: stat_now = STAT_MIDDLE;
            default: stat_now = STAT_BUSY;
        endcase
    end

    // enable gating and priority per half
    always_comb begin
        logic [IRQ_N-1:0] raw;
        raw = {q.flag, irq_src};
        cpu_irq_sel = prio_pick(raw & q.ie[IRQ_N-1:0]);
        dma_sel = prio_pick(raw & q.ie[IE_DMA_LO +: IRQ_N]);
    end

    // only sync modes that wait use the dma half events
    assign dma_event = (sync_f != SYNC_NONE) && (|dma_sel);

    // control register as read, with live status
    always_comb begin
        ctrl_view = q.ctrl & CTRL_WMASK;
        ctrl_view[CTRL_STAT_LO +: 2] = stat_now;
    end

    // next state of bus slave and sequencer
    always_comb begin
        logic wr_go;
        logic hit;
        logic set_flag;
        logic [31:0] wval;
        logic [1:0] after_rd;
        state_type post_rd;
        state_type to_wr;
        state_type to_rd;
        d = q;
        wr_go = 1'b0;
        hit = 1'b0;
        set_flag = 1'b0;
        wval = '0;
        after_rd = start_f;
        to_wr = (sync_f == SYNC_DST || sync_f == SYNC_BOTH) ?
            ST_WR_WAIT : ST_WR;
        to_rd = (sync_f == SYNC_SRC || sync_f == SYNC_BOTH) ?
            ST_RD_WAIT : ST_RD;
        post_rd = ST_IDLE;

        // response channels drop once taken
        if (q.bvalid && s_axi_bready) begin
            d.bvalid = 1'b0;
        end
        if (q.rvalid && s_axi_rready) begin
            d.rvalid = 1'b0;
        end

        // write address and data are held until both are present
        if (s_axi_awvalid && !q.aw_v) begin
            d.aw_v = 1'b1;
            d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !q.w_v) begin
            d.w_v = 1'b1;
            d.w_data = s_axi_wdata;
            d.w_strb = s_axi_wstrb;
        end
        if (q.aw_v && q.w_v && !q.bvalid) begin
            wr_go = 1'b1;
            d.aw_v = 1'b0;
            d.w_v = 1'b0;
            d.bvalid = 1'b1;
        end

        // read decode
        if (s_axi_arvalid && !q.rvalid) begin
            d.rvalid = 1'b1;
            d.rresp = RESP_OKAY;
            d.rdata = '0;
            if (addr_hit(s_axi_araddr, IDX_CTRL)) begin
                d.rdata = ctrl_view;
            end else if (addr_hit(s_axi_araddr, IDX_SRC)) begin
                d.rdata[ADDR_W-1:0] = q.src;
            end else if (addr_hit(s_axi_araddr, IDX_DST)) begin
                d.rdata[ADDR_W-1:0] = q.dst;
            end else if (addr_hit(s_axi_araddr, IDX_CNT)) begin
                d.rdata[CNT_W-1:0] = q.cnt;
            end else if (addr_hit(s_axi_araddr, IDX_IE)) begin
                d.rdata = q.ie & IE_WMASK;
            end else if (addr_hit(s_axi_araddr, IDX_STATUS)) begin
                d.rdata[STATUS_FLAG] = q.flag;
            end else begin
                d.rresp = RESP_SLVERR;
            end
        end

        // what follows the read phase, by the start field
        case (after_rd)
            START_RUN: post_rd = to_wr;
            START_XFER: post_rd = to_wr;
            START_PHASE: post_rd = ST_MID;
            default: post_rd = ST_IDLE;
        endcase

        // transfer sequencer
        case (q.state)
            ST_IDLE: begin
                if (start_f == START_RUN && can_run) begin
                    d.state = to_rd;
                end
            end
            ST_RD_WAIT: begin
                if (start_f != START_RUN || !can_run) begin
                    d.state = ST_IDLE;
                end else if (dma_event) begin
                    d.state = ST_RD;
                end
            end
            ST_RD: begin
                // bus cycle is never cut short, even on abort
                if (mem_ready) begin
                    d.data = mem_rdata;
                    d.src = step_addr(q.src, q.ctrl[CTRL_SRC_UP],
                        q.ctrl[CTRL_SRC_DOWN]);
                    if (is_external(q.src)) begin
                        d.state = ST_LOAD;
                    end else begin
                        d.state = post_rd;
                    end
                end
            end
            ST_LOAD: begin
                d.state = post_rd;
            end
            ST_MID: begin
                if (start_f == START_RUN) begin
                    d.state = to_wr;
                end else if (start_f == START_ABORT) begin
                    d.state = ST_IDLE;
                end
            end
            ST_WR_WAIT: begin
                if (start_f == START_ABORT) begin
                    d.state = ST_IDLE;
                end else if (start_f == START_PHASE) begin
                    d.state = ST_MID;
                end else if (dma_event) begin
                    d.state = ST_WR;
                end
            end
            ST_WR: begin
                if (mem_ready) begin
                    d.dst = step_addr(q.dst, q.ctrl[CTRL_DST_UP],
                        q.ctrl[CTRL_DST_DOWN]);
                    if (start_f == START_RUN && can_run) begin
                        d.state = to_rd;
                    end else begin
                        d.state = ST_IDLE;
                    end
                end
            end
            default: begin
                d.state = ST_IDLE;
            end
        endcase

        // the counter steps as the write phase begins
        if (d.state == ST_WR && q.state != ST_WR) begin
            d.cnt = q.cnt - CNT_W'(1);
            if (q.cnt == CNT_W'(1) && count_zero_irq_enable_f) begin
                set_flag = 1'b1;
            end
        end

        // software writes take the register over
        if (wr_go) begin
            hit = 1'b1;
            if (addr_hit(q.aw_addr, IDX_CTRL)) begin
                wval = merge_strb(q.ctrl, q.w_data, q.w_strb);
                d.ctrl = wval & CTRL_WMASK;
            end else if (addr_hit(q.aw_addr, IDX_SRC)) begin
                wval = merge_strb(32'(q.src), q.w_data, q.w_strb);
                d.src = wval[ADDR_W-1:0];
            end else if (addr_hit(q.aw_addr, IDX_DST)) begin
                wval = merge_strb(32'(q.dst), q.w_data, q.w_strb);
                d.dst = wval[ADDR_W-1:0];
            end else if (addr_hit(q.aw_addr, IDX_CNT)) begin
                wval = merge_strb(32'(q.cnt), q.w_data, q.w_strb);
                d.cnt = wval[CNT_W-1:0];
            end else if (addr_hit(q.aw_addr, IDX_IE)) begin
                wval = merge_strb(q.ie, q.w_data, q.w_strb);
                d.ie = wval & IE_WMASK;
            end else if (addr_hit(q.aw_addr, IDX_STATUS)) begin
                if (q.w_strb[0] && q.w_data[STATUS_FLAG]) begin
                    d.flag = 1'b0;
                end
            end else begin
                hit = 1'b0;
            end
            d.bresp = hit ? RESP_OKAY : RESP_SLVERR;
        end

        // a new zero count beats a clear in the same cycle
        if (set_flag) begin
            d.flag = 1'b1;
        end
    end

    // state register
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            q <= '0;
            q.ctrl <= CTRL_RESET;
            q.src <= ADDR_RESET;
            q.dst <= ADDR_RESET;
            q.cnt <= CNT_RESET;
            q.ie <= IE_RESET;
        end else begin
            q <= d;
        end
    end

    // bus slave handshakes
    assign s_axi_awready = !q.aw_v;
    assign s_axi_wready = !q.w_v;
    assign s_axi_arready = !q.rvalid;
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_bresp = q.bresp;
    assign s_axi_rvalid = q.rvalid;
    assign s_axi_rdata = q.rdata;
    assign s_axi_rresp = q.rresp;

    // memory port follows the sequencer phase
    assign mem_req = (q.state == ST_RD) || (q.state == ST_WR);
    assign mem_write = (q.state == ST_WR);
    assign mem_addr = mem_write ? q.dst : q.src;
    assign mem_external = is_external(mem_addr);
    assign mem_wdata = q.data;

    // visible status
    assign dma_irq_flag = q.flag;
    assign dma_stat = stat_now;

endmodule : dma_transfer_engine

// [dma_transfer_engine_asserts.sv]
// dma engine port assertions
`timescale 1ns/1ps
module dma_transfer_engine_asserts
    import dma_transfer_pkg::*;
#(
    parameter int ADDR_W = 24
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // register bus
    input wire logic s_axi_awready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_rvalid,
    // memory port
    input wire logic mem_req,
    input wire logic mem_write,
    input wire logic mem_external,
    input wire logic mem_ready,
    input wire logic [ADDR_W-1:0] mem_addr,
    input wire logic [31:0] mem_wdata,
    input wire logic [31:0] mem_rdata,
    // interrupts and status
    input wire logic [IRQ_N-2:0] irq_src,
    input wire logic [IRQ_N-1:0] cpu_irq_sel,
    input wire logic dma_irq_flag,
    input wire logic [1:0] dma_stat
);
    // single domain
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    // idle after reset
    property p_rst_idle;
        $fell(srst) |-> !mem_req && !dma_irq_flag && dma_stat == 2'b00
            && !s_axi_bvalid && !s_axi_rvalid;
    endproperty
    a_rst_idle: assert property (p_rst_idle)
        else $error("not idle after reset");

    // access held in wait
    property p_mem_hold;
        mem_req && !mem_ready |=> mem_req && $stable(mem_addr)
            && $stable(mem_write);
    endproperty
    a_mem_hold: assert property (p_mem_hold)
        else $error("access changed in wait");

    // word read is word written
    property p_wdata_load;
        mem_req && !mem_write && mem_ready && !mem_external
            |=> mem_wdata == $past(mem_rdata);
    endproperty
    a_wdata_load: assert property (p_wdata_load)
        else $error("write data wrong");

    // external read, then load cycle
    property p_ext_load;
        mem_req && !mem_write && mem_ready && mem_external |=> !mem_req;
    endproperty
    a_ext_load: assert property (p_ext_load)
        else $error("no load cycle");

    // one selected source at most, and it is pending
    property p_sel_prio;
        $onehot0(cpu_irq_sel) && (cpu_irq_sel[9:0] & ~irq_src) == 10'h000
            && (!cpu_irq_sel[10] || dma_irq_flag);
    endproperty
    a_sel_prio: assert property (p_sel_prio)
        else $error("bad cpu select");

    // access only while busy
    property p_busy_stat;
        mem_req |-> dma_stat == 2'b11;
    endproperty
    a_busy_stat: assert property (p_busy_stat)
        else $error("access while not busy");

    // flag kept unless written
    property p_flag_keep;
        dma_irq_flag && s_axi_awready |=> dma_irq_flag;
    endproperty
    a_flag_keep: assert property (p_flag_keep)
        else $error("flag dropped");

    // flag rises only when busy
    property p_flag_rise;
        $rose(dma_irq_flag) |-> dma_stat == 2'b11;
    endproperty
    a_flag_rise: assert property (p_flag_rise)
        else $error("flag rose while idle");

    // scenarios
    c_write: cover property (mem_req && mem_write && mem_ready);
    c_ext: cover property (mem_req && mem_external && !mem_ready);
    c_flag: cover property ($rose(dma_irq_flag));
    c_sel: cover property (cpu_irq_sel[10]);
endmodule : dma_transfer_engine_asserts

bind dma_transfer_engine dma_transfer_engine_asserts #(.ADDR_W(ADDR_W)) chk_i (
    .clk_sys, .srst, .s_axi_awready, .s_axi_bvalid, .s_axi_rvalid,
    .mem_req, .mem_write, .mem_external, .mem_ready, .mem_addr,
    .mem_wdata, .mem_rdata, .irq_src, .cpu_irq_sel, .dma_irq_flag,
    .dma_stat
);

// [dma_transfer_pkg.sv]
// constants and types shared by the dma transfer engine
package dma_transfer_pkg;

    // register indices; the bus byte address is four times the index
    localparam logic [5:0] IDX_CTRL = 6'h00;
    localparam logic [5:0] IDX_SRC = 6'h04;
    localparam logic [5:0] IDX_DST = 6'h06;
    localparam logic [5:0] IDX_CNT = 6'h08;
    localparam logic [5:0] IDX_IE = 6'h10;
    localparam logic [5:0] IDX_STATUS = 6'h11;

    // control register field positions
    localparam int CTRL_START_LO = 0;
    localparam int CTRL_STAT_LO = 2;
    localparam int CTRL_SRC_UP = 4;
    localparam int CTRL_SRC_DOWN = 5;
    localparam int CTRL_DST_UP = 6;
    localparam int CTRL_DST_DOWN = 7;
    localparam int CTRL_SYNC_LO = 8;
    localparam int CTRL_TERM = 10;
    localparam int CTRL_COUNT_ZERO_IRQ_ENABLE = 11;
    localparam logic [31:0] CTRL_WMASK = 32'h0000_0ff3;

    // interrupt enable layout: cpu half low, dma half from bit 16
    localparam int IRQ_N = 11;
    localparam int IE_DMA_LO = 16;
    localparam int IRQ_DMA_BIT = 10;
    localparam logic [31:0] IE_WMASK = 32'h07ff_07ff;

    // status register bit positions
    localparam int STATUS_FLAG = 0;

    // values after reset
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [23:0] ADDR_RESET = 24'h00_0000;
    localparam logic [23:0] CNT_RESET = 24'h00_0000;
    localparam logic [31:0] IE_RESET = 32'h0000_0000;

    // start field encodings
    localparam logic [1:0] START_ABORT = 2'b00;
    localparam logic [1:0] START_PHASE = 2'b01;
    localparam logic [1:0] START_XFER = 2'b10;
    localparam logic [1:0] START_RUN = 2'b11;

    // synchronisation field encodings
    localparam logic [1:0] SYNC_NONE = 2'b00;
    localparam logic [1:0] SYNC_SRC = 2'b01;
    localparam logic [1:0] SYNC_DST = 2'b10;
    localparam logic [1:0] SYNC_BOTH = 2'b11;

    // status field encodings
    localparam logic [1:0] STAT_BETWEEN = 2'b00;
    localparam logic [1:0] STAT_MIDDLE = 2'b01;
    localparam logic [1:0] STAT_BUSY = 2'b11;

    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // transfer sequencer states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_RD_WAIT = 3'b001,
        ST_RD = 3'b010,
        ST_LOAD = 3'b011,
        ST_MID = 3'b100,
        ST_WR_WAIT = 3'b101,
        ST_WR = 3'b110
    } state_type;

endpackage : dma_transfer_pkg

// [test_dma_transfer_engine.sv]
// self-checking testbench for the dma transfer engine
`timescale 1ns/1ps
module test_dma_transfer_engine
    import dma_transfer_pkg::*;
;
    localparam logic [7:0] A_CTRL = {IDX_CTRL, 2'b00},
        A_SRC = {IDX_SRC, 2'b00},
        A_DST = {IDX_DST, 2'b00},
        A_CNT = {IDX_CNT, 2'b00},
        A_IE = {IDX_IE, 2'b00},
        A_STS = {IDX_STATUS, 2'b00};
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [9:0] irq_src = 10'h000;
    logic [1:0] ext_waits = 2'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, mem_req, mem_write, mem_external, mem_ready;
    logic dma_irq_flag;
    logic [1:0] s_axi_bresp, s_axi_rresp, dma_stat, bresp_last, rresp_last;
    logic [31:0] s_axi_rdata, mem_wdata, mem_rdata;
    logic [23:0] mem_addr;
    logic [10:0] cpu_irq_sel;
    int fail_count = 0;
    int n_compared = 0;
    int cyc = 0, req_n = 0, rd_n = 0;

    dma_transfer_engine dut (
        .clk_sys, .srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .mem_req, .mem_write, .mem_external,
        .mem_addr, .mem_wdata, .mem_rdata, .mem_ready, .irq_src,
        .cpu_irq_sel, .dma_irq_flag, .dma_stat
    );
    dma_mem_model mdl (
        .clk_sys, .srst, .ext_waits, .mem_req, .mem_write, .mem_external,
        .mem_addr, .mem_wdata, .mem_rdata, .mem_ready
    );

    // 40 mhz clock
    always #12.5 clk_sys = ~clk_sys;
    // access counts and timeout
    always @(negedge clk_sys) begin
        req_n += int'(mem_req);
        rd_n += int'(mem_req && !mem_write);
    end
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            end_sim();
        end
    end

    // report and stop
    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_sim
    // compare and count
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    // register write
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_awvalid || s_axi_wvalid);
        do @(posedge clk_sys); while (s_axi_bvalid !== 1'b1);
        bresp_last = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr
    // register read and compare
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_sys);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge clk_sys); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge clk_sys); while (s_axi_rvalid !== 1'b1);
        rresp_last = s_axi_rresp;
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, e);
    endtask : rd_chk
    // load and start
    task automatic setup(input logic [31:0] s, t, c, ctl);
        wr(A_CTRL, 32'h0);
        wr(A_SRC, s);
        wr(A_DST, t);
        wr(A_CNT, c);
        req_n = 0;
        rd_n = 0;
        wr(A_CTRL, ctl);
    endtask : setup
    // wait for idle
    task automatic wait_idle();
        repeat (3) @(posedge clk_sys);
        while (dma_stat !== STAT_BETWEEN || mem_req !== 1'b0) begin
            @(posedge clk_sys);
        end
    endtask : wait_idle
    // one-cycle source event
    task automatic pulse(input int i);
        @(posedge clk_sys);
        irq_src <= 10'h001 << i;
        @(posedge clk_sys);
        irq_src <= 10'h000;
        chk(cpu_irq_sel, 32'h0);
    endtask : pulse

    // register map
    task automatic t_regs();
        rd_chk(A_CTRL, 32'h0);
        rd_chk(A_SRC, 32'h0);
        rd_chk(A_CNT, 32'h0);
        rd_chk(A_IE, 32'h0);
        wr(A_IE, 32'hffff_ffff);
        rd_chk(A_IE, 32'h07ff_07ff);
        wr(A_DST, 32'hffff_ffff);
        rd_chk(A_DST, 32'h00ff_ffff);
        wr(8'h0c, 32'h1);
        chk(bresp_last, RESP_SLVERR);
        rd_chk(8'h0c, 32'h0);
        chk(rresp_last, RESP_SLVERR);
    endtask : t_regs
    // cpu priority
    task automatic t_irq();
        wr(A_IE, 32'h3ff);
        for (int i = 0; i < 10; i++) begin
            @(posedge clk_sys);
            irq_src <= 10'h3ff << i;
            @(posedge clk_sys);
            chk(cpu_irq_sel, 32'h1 << i);
        end
        wr(A_IE, 32'h3fe);
        chk(cpu_irq_sel, 32'h200);
        irq_src <= 10'h000;
        wr(A_IE, 32'h0);
    endtask : t_irq
    // on-chip block
    task automatic t_onchip();
        setup(32'h80_0000, 32'h80_0008, 32'h2, 32'h0c53);
        wait_idle();
        chk(req_n, 4);
        chk(mdl.mem_q[24], 32'ha5a5_0010);
        chk(mdl.mem_q[25], 32'ha5a5_0011);
        rd_chk(A_SRC, 32'h80_0002);
        rd_chk(A_DST, 32'h80_000a);
        rd_chk(A_CNT, 32'h0);
        chk(dma_irq_flag, 1'b1);
        repeat (10) @(posedge clk_sys);
        chk(req_n, 4);
        rd_chk(A_STS, 32'h1);
        wr(A_IE, 32'h400);
        chk(cpu_irq_sel, 32'h400);
        wr(A_STS, 32'h1);
        chk(dma_irq_flag, 1'b0);
        wr(A_IE, 32'h0);
    endtask : t_onchip
    // external read
    task automatic t_ext();
        ext_waits <= 2'h1;
        setup(32'h00_0010, 32'h80_0010, 32'h1, 32'h04b3);
        wait_idle();
        chk(rd_n, 2);
        chk(mdl.mem_q[16], 32'ha5a5_0000);
        rd_chk(A_SRC, 32'h00_0010);
        rd_chk(A_DST, 32'h80_000f);
        chk(dma_irq_flag, 1'b0);
        ext_waits <= 2'h0;
    endtask : t_ext
    // source sync
    task automatic t_sync();
        wr(A_IE, 32'h1_0000);
        setup(32'h80_0003, 32'h80_0014, 32'h1, 32'h0503);
        repeat (10) @(posedge clk_sys);
        pulse(1);
        repeat (5) @(posedge clk_sys);
        chk(req_n, 0);
        pulse(0);
        wait_idle();
        chk(rd_n, 1);
        chk(mdl.mem_q[20], 32'ha5a5_0013);
    endtask : t_sync
    // stop and resume
    task automatic t_stop();
        setup(32'h80_0005, 32'h80_0016, 32'h1, 32'h0603);
        repeat (10) @(posedge clk_sys);
        chk(dma_stat, STAT_BUSY);
        chk(mdl.mem_q[22], 32'ha5a5_0016);
        wr(A_CTRL, 32'h0601);
        repeat (2) @(posedge clk_sys);
        chk(dma_stat, STAT_MIDDLE);
        wr(A_IE, 32'h2_0000);
        wr(A_CTRL, 32'h0603);
        pulse(1);
        wait_idle();
        chk(rd_n, 1);
        chk(mdl.mem_q[22], 32'ha5a5_0015);
    endtask : t_stop

    // main sequence
    initial begin
        repeat (3) @(posedge clk_sys);
        srst <= 1'b0;
        t_regs();
        t_irq();
        t_onchip();
        t_ext();
        t_sync();
        t_stop();
        end_sim();
    end
endmodule : test_dma_transfer_engine
